// ==== dpf_playback_filter.v ====
// Playback sample path with mono mix, de-emphasis, stopband choice and bias/rate controls.
`default_nettype none
`include "dpf_regs.vh"

module dpf_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Fill side.
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side.
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // Fill level.
  output wire [AW:0] level_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full;
  wire empty;
  wire push;
  wire pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign level_o = wr_ptr - rd_ptr;

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // dpf_fifo

module dpf_playback_filter (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone classic slave.
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Channel enables from the power control logic.
  input wire dac_left_en_i,
  input wire dac_right_en_i,
  // Incoming stereo samples.
  input wire smp_valid_i,
  output wire smp_ready_o,
  input wire [15:0] smp_left_i,
  input wire [15:0] smp_right_i,
  // Samples toward the modulators.
  output reg dac_valid_o,
  input wire dac_ready_i,
  output reg [15:0] dac_left_o,
  output reg [15:0] dac_right_o,
  // Modulator and analogue controls.
  output reg mod_tick_o,
  output reg osr_double_o,
  output reg sloping_stopband_o,
  output reg [7:0] converter_bias_level_o,
  output reg [7:0] midrail_bias_level_o
);
  reg [15:0] bias_cfg;
  reg [15:0] play_cfg;
  reg [7:0] mod_cnt;
  reg [15:0] slope_prev [0:1];
  reg [15:0] emph_x1 [0:1];
  reg [15:0] emph_y1 [0:1];
  wire [31:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  wire [4:0] fifo_level;
  wire wb_req;
  wire [5:0] wb_idx;
  wire [15:0] wmask;
  wire [15:0] lane_data;
  wire mono_on;
  wire [1:0] emph_sel;
  wire [16:0] mono_sum;
  wire [15:0] mono_half;
  wire [15:0] mixed [0:1];
  wire [15:0] emph_out [0:1];
  wire [15:0] final_out [0:1];
  wire [1:0] chan_en;
  wire [7:0] next_conv_level;
  wire [7:0] next_mid_level;
  wire [7:0] mod_div;

  // Saturates a wide filter result back to 16-bit signed.
  function [15:0] sat16;
    input signed [33:0] v;
    begin
      if (v > 34'sd32767) begin
        sat16 = 16'h7FFF;
      end else if (v < -34'sd32768) begin
        sat16 = 16'h8000;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  // Maps a two-bit bias select onto a level in hundredths of normal.
  function [7:0] bias_level;
    input [1:0] code;
    input dbl;
    reg [7:0] base;
    begin
      case (code)
        2'h0: base = `DPF_LVL_NORMAL;
        2'h1: base = `DPF_LVL_HALF;
        2'h2: base = `DPF_LVL_066;
        default: base = `DPF_LVL_075;
      endcase
      bias_level = dbl ? {base[6:0], 1'b0} : base;
    end
  endfunction

  // Picks one de-emphasis coefficient: 0 is b0, 1 is b1, 2 is a1, all Q15.
  function [15:0] emph_coef;
    input [1:0] sel;
    input [1:0] which;
    begin
      case (sel)
        `DPF_EMPH_32K: emph_coef = (which == 2'h0) ? `DPF_B0_32K :
                                   (which == 2'h1) ? `DPF_B1_32K : `DPF_A1_32K;
        `DPF_EMPH_44K: emph_coef = (which == 2'h0) ? `DPF_B0_44K :
                                   (which == 2'h1) ? `DPF_B1_44K : `DPF_A1_44K;
        `DPF_EMPH_48K: emph_coef = (which == 2'h0) ? `DPF_B0_48K :
                                   (which == 2'h1) ? `DPF_B1_48K : `DPF_A1_48K;
        default: emph_coef = 16'h0000;
      endcase
    end
  endfunction

  // The FIFO absorbs bursts from the audio interface while the modulators stall.
  dpf_fifo #(
    .WIDTH(32),
    .DEPTH(16),
    .AW(4)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(smp_valid_i),
    .in_ready_o(smp_ready_o),
    .in_data_i({smp_left_i, smp_right_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data),
    .level_o(fifo_level)
  );

  assign fifo_pop = fifo_valid && (!dac_valid_o || dac_ready_i);

  // Register bus decode.
  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_idx = adr_i[7:2];
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign lane_data = dat_i[15:0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      bias_cfg <= `DPF_BIAS_RESET;
      play_cfg <= `DPF_PLAY_RESET;
    end else begin
      ack_o <= wb_req;
      if (wb_req && we_i) begin
        if (wb_idx == `DPF_IDX_BIAS) begin
          bias_cfg <= ((bias_cfg & ~wmask) | (lane_data & wmask)) & `DPF_BIAS_MASK;
        end
        if (wb_idx == `DPF_IDX_PLAY) begin
          play_cfg <= ((play_cfg & ~wmask) | (lane_data & wmask)) & `DPF_PLAY_MASK;
        end
      end
      if (wb_req && !we_i) begin
        case (wb_idx)
          `DPF_IDX_BIAS: dat_o <= {16'h0000, bias_cfg};
          `DPF_IDX_PLAY: dat_o <= {16'h0000, play_cfg};
          `DPF_IDX_STAT: dat_o <= {16'h0000, 8'h00, dac_valid_o, 2'h0, fifo_level};
          default: dat_o <= 32'h00000000;
        endcase
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

  // Sample processing: mix, then de-emphasis, then the selected stopband response.
  assign mono_on = play_cfg[`DPF_BIT_MONO];
  assign emph_sel = play_cfg[`DPF_EMPH_HI:`DPF_EMPH_LO];
  assign chan_en = {dac_left_en_i, dac_right_en_i};
  assign mono_sum = {fifo_data[31], fifo_data[31:16]} + {fifo_data[15], fifo_data[15:0]};
  // Halving the sum is the 6 dB drop, and it cannot overflow 16 bits.
  assign mono_half = mono_sum[16:1];
  // In mono the mix feeds both lanes; the channel enable then picks the live DAC.
  assign mixed[1] = mono_on ? mono_half : fifo_data[31:16];
  assign mixed[0] = mono_on ? mono_half : fifo_data[15:0];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire signed [31:0] p_b0;
      wire signed [31:0] p_b1;
      wire signed [31:0] p_a1;
      wire signed [33:0] acc;
      wire [16:0] slope_sum;

      assign p_b0 = $signed(mixed[ch]) * $signed(emph_coef(emph_sel, 2'h0));
      assign p_b1 = $signed(emph_x1[ch]) * $signed(emph_coef(emph_sel, 2'h1));
      assign p_a1 = $signed(emph_y1[ch]) * $signed(emph_coef(emph_sel, 2'h2));
      assign acc = ($signed({{2{p_b0[31]}}, p_b0}) + $signed({{2{p_b1[31]}}, p_b1})
                    + $signed({{2{p_a1[31]}}, p_a1})) >>> 15;
      assign emph_out[ch] = (emph_sel == `DPF_EMPH_NONE) ? mixed[ch] : sat16(acc);
      // The two-tap average puts a zero at half the sample rate for a sloping stopband.
      assign slope_sum = {emph_out[ch][15], emph_out[ch]} + {slope_prev[ch][15], slope_prev[ch]};
      assign final_out[ch] = play_cfg[`DPF_BIT_SLOPE] ? slope_sum[16:1] : emph_out[ch];

      always @(posedge clk_i) begin
        if (rst_i) begin
          emph_x1[ch] <= 16'h0000;
          emph_y1[ch] <= 16'h0000;
          slope_prev[ch] <= 16'h0000;
        end else if (fifo_pop) begin
          emph_x1[ch] <= mixed[ch];
          emph_y1[ch] <= emph_out[ch];
          slope_prev[ch] <= emph_out[ch];
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      dac_valid_o <= 1'b0;
      dac_left_o <= 16'h0000;
      dac_right_o <= 16'h0000;
    end else if (fifo_pop) begin
      dac_valid_o <= 1'b1;
      // A disabled DAC gets silence so a mono mix lands only on the live one.
      dac_left_o <= chan_en[1] ? final_out[1] : 16'h0000;
      dac_right_o <= chan_en[0] ? final_out[0] : 16'h0000;
    end else if (dac_ready_i) begin
      dac_valid_o <= 1'b0;
    end
  end

  // Modulator rate and analogue bias controls.
  assign mod_div = play_cfg[`DPF_BIT_OSR] ? `DPF_MOD_DIV_DOUBLE : `DPF_MOD_DIV_NORMAL;
  assign next_conv_level = bias_level(bias_cfg[`DPF_CONV_HI:`DPF_CONV_LO],
                                      bias_cfg[`DPF_BIT_DOUBLE]);
  assign next_mid_level = bias_level(bias_cfg[`DPF_MID_HI:`DPF_MID_LO],
                                     bias_cfg[`DPF_BIT_DOUBLE]);

  always @(posedge clk_i) begin
    if (rst_i) begin
      mod_cnt <= 8'h00;
      mod_tick_o <= 1'b0;
      osr_double_o <= 1'b0;
      sloping_stopband_o <= 1'b0;
      converter_bias_level_o <= `DPF_LVL_NORMAL;
      midrail_bias_level_o <= `DPF_LVL_NORMAL;
    end else begin
      // A rate change mid-count ends the current period early rather than late.
      if (mod_cnt >= mod_div - 8'h01) begin
        mod_cnt <= 8'h00;
        mod_tick_o <= 1'b1;
      end else begin
        mod_cnt <= mod_cnt + 8'h01;
        mod_tick_o <= 1'b0;
      end
      osr_double_o <= play_cfg[`DPF_BIT_OSR];
      sloping_stopband_o <= play_cfg[`DPF_BIT_SLOPE];
      converter_bias_level_o <= next_conv_level;
      midrail_bias_level_o <= next_mid_level;
    end
  end
endmodule // dpf_playback_filter
`default_nettype wire

// ==== dpf_playback_filter_sva.sv ====
// Checker for the register bus, bias level outputs and modulator tick.
`default_nettype none
`include "dpf_regs.vh"
module dpf_playback_filter_sva (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  // Controls.
  input wire logic mod_tick_o,
  input wire logic osr_double_o,
  input wire logic sloping_stopband_o,
  input wire logic [7:0] converter_bias_level_o,
  input wire logic [7:0] midrail_bias_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  function automatic logic [7:0] lvl(input logic [1:0] c, input logic d);
    logic [7:0] v;
    case (c)
      2'h0: v = `DPF_LVL_NORMAL;
      2'h1: v = `DPF_LVL_HALF;
      2'h2: v = `DPF_LVL_066;
      default: v = `DPF_LVL_075;
    endcase
    return d ? {v[6:0], 1'b0} : v;
  endfunction
  logic req;
  logic wr_bias;
  logic wr_play;
  assign req = cyc_i && stb_i && !ack_o;
  assign wr_bias = req && we_i && sel_i[1:0] == 2'h3 && adr_i == `DPF_ADR_BIAS;
  assign wr_play = req && we_i && sel_i[1:0] == 2'h3 && adr_i == `DPF_ADR_PLAY;
  property p_ack; req |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_conv;
    wr_bias |-> ##2 converter_bias_level_o == lvl($past(dat_i[4:3], 2), $past(dat_i[5], 2));
  endproperty
  a_conv: assert property (p_conv) else $error("converter level wrong");
  property p_mid;
    wr_bias |-> ##2 midrail_bias_level_o == lvl($past(dat_i[2:1], 2), $past(dat_i[5], 2));
  endproperty
  a_mid: assert property (p_mid) else $error("midrail level wrong");
  property p_slope; wr_play |-> ##2 sloping_stopband_o == $past(dat_i[11], 2); endproperty
  a_slope: assert property (p_slope) else $error("stopband select wrong");
  property p_osr; wr_play |-> ##2 osr_double_o == $past(dat_i[0], 2); endproperty
  a_osr: assert property (p_osr) else $error("rate select wrong");
  property p_tick16; mod_tick_o && osr_double_o |-> ##16 (mod_tick_o || !osr_double_o); endproperty
  a_tick16: assert property (p_tick16) else $error("double rate tick");
  property p_tick32; mod_tick_o && !osr_double_o |-> ##32 (mod_tick_o || osr_double_o); endproperty
  a_tick32: assert property (p_tick32) else $error("normal rate tick");
endmodule // dpf_playback_filter_sva
bind dpf_playback_filter dpf_playback_filter_sva dpf_playback_filter_sva_i (.*);
`default_nettype wire

// ==== dpf_playback_filter_test.sv ====
// Self-checking testbench of the playback filter block.
`default_nettype none
`include "dpf_regs.vh"
module dpf_playback_filter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic dac_left_en_i = 1'b1, dac_right_en_i = 1'b1, smp_valid_i = 1'b0, smp_ready_o;
  logic [15:0] smp_left_i = 16'h0, smp_right_i = 16'h0, dac_left_o, dac_right_o, ol, orr;
  logic dac_valid_o, dac_ready_i = 1'b1, mod_tick_o, osr_double_o, sloping_stopband_o;
  logic [7:0] converter_bias_level_o, midrail_bias_level_o, e;
  logic [7:0] lv [4] = '{8'h64, 8'h32, 8'h42, 8'h4B};
  logic [15:0] em [4] = '{16'h4000, 16'h21CE, 16'h1D70, 16'h1C3C};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  dpf_playback_filter dpf_playback_filter_i (.*);
  always #2 clk_i = ~clk_i;
  // The whole run needs well under 5000 cycles, so this only trips on a hang.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task ck(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task push(input logic [15:0] l, input logic [15:0] r);
    @(posedge clk_i);
    smp_valid_i <= 1'b1;
    smp_left_i <= l;
    smp_right_i <= r;
    do @(posedge clk_i); while (smp_ready_o !== 1'b1);
    smp_valid_i <= 1'b0;
    do @(posedge clk_i); while (dac_valid_o !== 1'b1);
    ol = dac_left_o;
    orr = dac_right_o;
  endtask
  task t_regs;
    ck(converter_bias_level_o, 32'h64);
    wb(`DPF_ADR_BIAS, 1'b0, 16'h0);
    ck(q, `DPF_BIAS_RESET);
    wb(`DPF_ADR_PLAY, 1'b0, 16'h0);
    ck(q, `DPF_PLAY_RESET);
    wb(`DPF_ADR_BIAS, 1'b1, 16'hFFFF);
    wb(`DPF_ADR_BIAS, 1'b0, 16'h0);
    ck(q, `DPF_BIAS_MASK);
    wb(`DPF_ADR_PLAY, 1'b1, 16'hFFFF);
    wb(`DPF_ADR_PLAY, 1'b0, 16'h0);
    ck(q, `DPF_PLAY_MASK);
    wb(8'h40, 1'b1, 16'hFFFF);
    wb(8'h40, 1'b0, 16'h0);
    ck(q, 32'h0);
    $display("test regs done");
  endtask
  task t_bias;
    for (int i = 0; i < 8; i++) begin
      wb(`DPF_ADR_BIAS, 1'b1, {10'h0, i[2], i[1:0], i[1:0], 1'b0});
      @(posedge clk_i);
      e = i[2] ? {lv[i[1:0]][6:0], 1'b0} : lv[i[1:0]];
      ck(converter_bias_level_o, e);
      ck(midrail_bias_level_o, e);
    end
    // Doubling with the midrail field at half brings the buffer back to normal.
    wb(`DPF_ADR_BIAS, 1'b1, 16'h0022);
    @(posedge clk_i);
    ck(midrail_bias_level_o, 32'h64);
    ck(converter_bias_level_o, 32'hC8);
    $display("test bias done");
  endtask
  task t_path;
    wb(`DPF_ADR_PLAY, 1'b1, 16'h0);
    push(16'h1234, 16'h8765);
    ck({ol, orr}, 32'h12348765);
    dac_right_en_i <= 1'b0;
    wb(`DPF_ADR_PLAY, 1'b1, 16'h1000);
    push(16'h1000, 16'h3000);
    ck({ol, orr}, 32'h20000000);
    push(16'hFFFD, 16'h0000);
    ck({ol, orr}, 32'hFFFE0000);
    dac_left_en_i <= 1'b0;
    dac_right_en_i <= 1'b1;
    push(16'h0002, 16'h0004);
    ck({ol, orr}, 32'h00000003);
    dac_left_en_i <= 1'b1;
    $display("test path done");
  endtask
  task t_emph;
    for (int c = 0; c < 4; c++) begin
      wb(`DPF_ADR_PLAY, 1'b1, 16'h0);
      push(16'h0, 16'h0);
      wb(`DPF_ADR_PLAY, 1'b1, {13'h0, c[1:0], 1'b0});
      push(16'h4000, 16'h4000);
      ck({ol, orr}, {em[c], em[c]});
    end
    $display("test emphasis done");
  endtask
  task t_slope;
    wb(`DPF_ADR_PLAY, 1'b1, 16'h0801);
    push(16'h0100, 16'h0100);
    push(16'h0300, 16'h0300);
    ck({ol, orr}, 32'h02000200);
    ck(sloping_stopband_o, 1'b1);
    ck(osr_double_o, 1'b1);
    repeat (40) @(posedge clk_i);
    wb(`DPF_ADR_PLAY, 1'b1, 16'h0);
    repeat (70) @(posedge clk_i);
    $display("test slope done");
  endtask
  task t_fifo;
    dac_ready_i <= 1'b0;
    smp_valid_i <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge clk_i);
      if (smp_ready_o === 1'b1) n++;
    end
    smp_valid_i <= 1'b0;
    ck(n, 17);
    // A full buffer with a held output shows level 16 and the valid flag.
    wb(`DPF_ADR_STAT, 1'b0, 16'h0);
    ck(q, 32'h00000090);
    dac_ready_i <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge clk_i);
      if (dac_valid_o === 1'b1 && dac_ready_i) n++;
    end
    ck(n, 17);
    $display("test fifo done");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_bias;
    t_path;
    t_emph;
    t_slope;
    t_fifo;
    finish_test();
  end
endmodule // dpf_playback_filter_test
`default_nettype wire

// ==== dpf_regs.vh ====
// Register map, field layout and constants of the playback filter block.
// Summary of operation
// - Mono bit mixes left and right to enabled DAC
// - Mono mix is attenuated by 6 dB
// - Emphasis field picks none, 32k, 44.1k, 48k
// - Stopband bit picks normal or sloping filter
// - Oversample bit picks normal or double rate
// - Bias double bit doubles both bias levels
// - Converter field sets normal, half, 0.66, 0.75 bias
// - Midrail field sets normal, half, 0.66, 0.75 bias
`ifndef DPF_REGS_VH
`define DPF_REGS_VH

`define DPF_IDX_BIAS 6'h08
`define DPF_IDX_PLAY 6'h21
`define DPF_IDX_STAT 6'h22
`define DPF_ADR_BIAS 8'h20
`define DPF_ADR_PLAY 8'h84
`define DPF_ADR_STAT 8'h88

`define DPF_BIAS_RESET 16'h0000
`define DPF_PLAY_RESET 16'h0000
`define DPF_BIAS_MASK 16'h003E
`define DPF_PLAY_MASK 16'h1807

`define DPF_BIT_DOUBLE 5
`define DPF_CONV_HI 4
`define DPF_CONV_LO 3
`define DPF_MID_HI 2
`define DPF_MID_LO 1
`define DPF_BIT_MONO 12
`define DPF_BIT_SLOPE 11
`define DPF_EMPH_HI 2
`define DPF_EMPH_LO 1
`define DPF_BIT_OSR 0

`define DPF_EMPH_NONE 2'h0
`define DPF_EMPH_32K 2'h1
`define DPF_EMPH_44K 2'h2
`define DPF_EMPH_48K 2'h3

`define DPF_LVL_NORMAL 8'h64
`define DPF_LVL_HALF 8'h32
`define DPF_LVL_066 8'h42
`define DPF_LVL_075 8'h4B

`define DPF_MOD_DIV_NORMAL 8'h20
`define DPF_MOD_DIV_DOUBLE 8'h10

`define DPF_B0_32K 16'h439C
`define DPF_B1_32K 16'hF82B
`define DPF_A1_32K 16'h443A
`define DPF_B0_44K 16'h3AE0
`define DPF_B1_44K 16'hF4EA
`define DPF_A1_44K 16'h5036
`define DPF_B0_48K 16'h3879
`define DPF_B1_48K 16'hF429
`define DPF_A1_48K 16'h535E

`endif
